//--- hw/acsp_pkg.sv
package acsp_pkg;

	// frame and register geometry
	localparam int FRAME_BITS      = 24;
	localparam int CNT_W           = 5;
	localparam int REG_W           = 24;
	localparam int NUM_OUT_DEF     = 6;
	localparam int PWM2_OUT_DEF    = 4;

	// control word bit positions
	localparam int SEL_BIT         = 0;
	localparam int OUT_LSB         = 1;
	localparam int CM_SEL_LSB      = 18;
	localparam int CM_SEL_W        = 2;
	localparam int SUP_REC_DIS_BIT = 20;
	localparam int RESET_BIT       = 22;
	localparam int ENABLE_BIT      = 23;
	localparam int PWM_EN_LSB      = 1;
	localparam int REC_EN_LSB      = 7;
	localparam int FREQ_SEL_BIT    = 19;
	localparam int DUTY_SEL_BIT    = 21;

	// fault report bit positions
	localparam int ST_NOERR_BIT    = 0;
	localparam int ST_ERR_LSB      = 1;
	localparam int ST_ERR_MSB      = 22;
	localparam int ST_OC_LSB       = 1;
	localparam int ST_TW_BIT       = 19;
	localparam int ST_TSD_BIT      = 20;
	localparam int ST_UV_BIT       = 21;
	localparam int ST_OV_BIT       = 22;
	localparam int ST_ONE_BIT      = 23;

	// reset values
	localparam logic [REG_W-1:0] CTL_RST  = 24'h000000;
	localparam logic [REG_W-1:0] STAT_RST = 24'h800000;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
	localparam logic [CNT_W-1:0] CNT_SAT  = 5'h19;

	// timing
	localparam int CLK_MHZ         = 250;
	localparam int CLK_HZ          = 250_000_000;
	localparam int FILT_US         = 32;
	localparam int FILT_CYC_DEF    = FILT_US * CLK_MHZ;
	localparam int REC_FREQ_LO_HZ  = 1500;
	localparam int REC_FREQ_HI_HZ  = 3000;
	localparam int REC_PER_LO_DEF  = CLK_HZ / REC_FREQ_LO_HZ;
	localparam int REC_PER_HI_DEF  = CLK_HZ / REC_FREQ_HI_HZ;
	localparam int DUTY_LO_PCT     = 15;
	localparam int DUTY_HI_PCT     = 25;
	localparam int PCT_FULL        = 100;

endpackage

//--- hw/acsp_top.sv
// Contract
// - each output has a recovery bit; when set, tripped output restarts automatically
// - recovery duty cycle programmable over serial port, roughly 15 to 25 percent
// - recovery pulses repeat at 1.5 kHz or 3 kHz
// - recovery bit cleared with overload still present keeps output disabled
// - clock idles low; data sampled on rising, output changed on falling edge
// - frames go least significant bit first in both directions
// - select low before any clock shows the global fault bit on serial out
// - select high tristates serial out; select low opens a frame until rise
// - 24-bit shift register commits at select rise only after exactly 24 clocks
// - first rising clock loads selected status, falling edges shift next bits
// - first received bit picks input register and returned status register
// - input register bits 1 to 6 steer the individual drivers
// - bit 23 zero means standby and clears latches; one means active
// - bits 18 and 19 of register zero pick the monitored output
// - accepted frame with bit 22 clears both status registers at select rise
// - status bit 0 is NOR of bits 1 to 22 of both status registers
// - over-current flag disables its driver until cleared, unless recovering
// - thermal shutdown flag turns all drivers off until cleared
// - status bit 23 always reads one
// - status zero bit 22 flags supply fault; outputs off while flagged
// - over-current flag sets only after condition persists 32 microseconds
// - modulation enable makes output the AND of modulation input and control bit
// - supply recovery disable keeps outputs off until status is cleared
`timescale 1ns/1ps
module acsp_top #(
	parameter int NUM_OUT    = acsp_pkg::NUM_OUT_DEF,
	parameter int PWM2_OUT   = acsp_pkg::PWM2_OUT_DEF,
	parameter int FILT_CYC   = acsp_pkg::FILT_CYC_DEF,
	parameter int REC_PER_LO = acsp_pkg::REC_PER_LO_DEF,
	parameter int REC_PER_HI = acsp_pkg::REC_PER_HI_DEF
) (
	input  wire logic                            core_clk_i,                         // core clock
	input  wire logic                            resetn_i,                           // async reset
	input  wire logic                            sclk_i,                             // serial clock
	input  wire logic                            select_low_input_n_i,               // frame select
	input  wire logic                            serial_in_pin_i,                    // serial data in
	output logic                                 serial_out_o,                       // serial data out
	output logic                                 serial_out_oe_o,                    // out enable
	input  wire logic [NUM_OUT-1:0]              overcurrent_i,                      // raw overload
	input  wire logic                            overvoltage_i,                      // raw supply high
	input  wire logic                            undervoltage_i,                     // raw supply low
	input  wire logic                            thermal_shutdown_flag_i,            // raw overtemp
	input  wire logic                            temp_warning_i,                     // raw warning
	input  wire logic                            first_modulation_input_i,           // modulation 1
	input  wire logic                            monitor_or_second_modulation_pin_i, // modulation 2
	output logic [NUM_OUT-1:0]                   driver_on_o,                        // driver enables
	output logic [acsp_pkg::CM_SEL_W-1:0]        monitor_sel_o,                      // monitor mux
	output logic                                 active_o                            // not standby
);
	import acsp_pkg::*;

	localparam int IX_OV   = NUM_OUT;
	localparam int IX_UV   = NUM_OUT + 1;
	localparam int IX_TSD  = NUM_OUT + 2;
	localparam int IX_TW   = NUM_OUT + 3;
	localparam int IX_FIRST_MODULATION_INPUT = NUM_OUT + 4;
	localparam int IX_PWM2 = NUM_OUT + 5;
	localparam int IX_CSN  = NUM_OUT + 6;
	localparam int NF      = NUM_OUT + 4;
	localparam int NS      = NUM_OUT + 7;
	localparam int FILT_W  = $clog2(FILT_CYC + 1);
	localparam int REC_W   = $clog2(REC_PER_LO + 1);
	localparam int ON_LO_L = (REC_PER_LO / PCT_FULL) * DUTY_LO_PCT;
	localparam int ON_LO_H = (REC_PER_LO / PCT_FULL) * DUTY_HI_PCT;
	localparam int ON_HI_L = (REC_PER_HI / PCT_FULL) * DUTY_LO_PCT;
	localparam int ON_HI_H = (REC_PER_HI / PCT_FULL) * DUTY_HI_PCT;

	////////////////////////////////////////////////////////////////////////////////
	// link domain: serial clock, idle low, only acts while select is low

	logic                   first_reg;
	logic [REG_W-1:0]       rx_word_reg;
	logic [CNT_W-1:0]       rx_cnt_reg;
	logic                   rx_tog_reg;
	logic [REG_W-1:0]       tx_word_reg;
	logic [CNT_W-1:0]       tx_idx_reg;
	logic [REG_W-1:0]       hold0_reg;
	logic [REG_W-1:0]       hold1_reg;
	logic                   nerr_reg;

	// select high re-arms the frame without needing a clock edge
	always_ff @(posedge sclk_i or posedge select_low_input_n_i or negedge resetn_i) begin
		if (!resetn_i)
			first_reg <= 1'b1;
		else if (select_low_input_n_i)
			first_reg <= 1'b1;
		else
			first_reg <= 1'b0;
	end

	// lsb first: new bit enters at the top, first bit ends at bit 0
	always_ff @(posedge sclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_word_reg <= '0;
			rx_cnt_reg  <= '0;
			rx_tog_reg  <= 1'b0;
		end else if (!select_low_input_n_i) begin
			rx_word_reg <= {serial_in_pin_i, rx_word_reg[REG_W-1:1]};
			if (first_reg) begin
				rx_cnt_reg <= CNT_W'(1);
				rx_tog_reg <= !rx_tog_reg;
			end else if (rx_cnt_reg != CNT_SAT)
				rx_cnt_reg <= rx_cnt_reg + 1'b1;
		end
	end

	// first rising edge latches the status chosen by the first data bit
	always_ff @(posedge sclk_i or negedge resetn_i) begin
		if (!resetn_i)
			tx_word_reg <= STAT_RST;
		else if (!select_low_input_n_i && first_reg)
			tx_word_reg <= serial_in_pin_i ? hold1_reg : hold0_reg;
	end

	always_ff @(negedge sclk_i or posedge select_low_input_n_i or negedge resetn_i) begin
		if (!resetn_i)
			tx_idx_reg <= '0;
		else if (select_low_input_n_i)
			tx_idx_reg <= '0;
		else if (tx_idx_reg != CNT_W'(FRAME_BITS - 1))
			tx_idx_reg <= tx_idx_reg + 1'b1;
	end

	assign serial_out_o    = first_reg ? nerr_reg : tx_word_reg[tx_idx_reg];
	assign serial_out_oe_o = !select_low_input_n_i;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [NS-1:0]          async_in;
	logic [NS-1:0]          sync1_reg;
	logic [NS-1:0]          sync2_reg;
	logic                   csn_d_reg;

	assign async_in = {select_low_input_n_i, monitor_or_second_modulation_pin_i,
		first_modulation_input_i, temp_warning_i, thermal_shutdown_flag_i,
		undervoltage_i, overvoltage_i, overcurrent_i};

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_reg <= {1'b1, {(NS-1){1'b0}}}; // select idles high: no false rise
			sync2_reg <= {1'b1, {(NS-1){1'b0}}};
			csn_d_reg <= 1'b1;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
			csn_d_reg <= sync2_reg[IX_CSN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame commit: the link words are static once select has risen

	logic                   csn_rise;
	logic                   frame_end;
	logic                   commit;
	logic                   tog_seen_reg;
	logic [REG_W-1:0]       ctl0_reg;
	logic [REG_W-1:0]       ctl1_reg;

	assign csn_rise  = sync2_reg[IX_CSN] && !csn_d_reg;
	assign frame_end = csn_rise;
	assign commit    = frame_end && (rx_tog_reg != tog_seen_reg)
		&& (rx_cnt_reg == CNT_FULL);
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			tog_seen_reg <= 1'b0;
		else if (frame_end) // a poll has no clocks and leaves the old count
			tog_seen_reg <= rx_tog_reg;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctl0_reg <= CTL_RST;
			ctl1_reg <= CTL_RST;
		end else if (commit) begin
			if (rx_word_reg[SEL_BIT])
				ctl1_reg <= rx_word_reg;
			else
				ctl0_reg <= rx_word_reg;
		end
	end

	assign active_o      = ctl0_reg[ENABLE_BIT];
	assign monitor_sel_o = ctl0_reg[CM_SEL_LSB +: CM_SEL_W];

	////////////////////////////////////////////////////////////////////////////////
	// diagnostic filters

	logic [NF-1:0]          filt;

	for (genvar gi = 0; gi < NF; gi++) begin : g_filt
		logic [FILT_W-1:0] cnt_reg;
		always_ff @(posedge core_clk_i or negedge resetn_i) begin
			if (!resetn_i)
				cnt_reg <= '0;
			else if (!sync2_reg[gi])
				cnt_reg <= '0;
			else if (cnt_reg != FILT_W'(FILT_CYC))
				cnt_reg <= cnt_reg + 1'b1;
		end
		assign filt[gi] = (cnt_reg == FILT_W'(FILT_CYC));
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault report registers

	logic [REG_W-1:0]       stat0_reg;
	logic [REG_W-1:0]       stat1_reg;
	logic [REG_W-1:0]       set0;
	logic [REG_W-1:0]       set1;
	logic                   stat_clr;
	logic                   nerr_next;

	always_comb begin
		set0 = '0;
		set1 = '0;
		set0[ST_OV_BIT]  = filt[IX_OV];
		set0[ST_UV_BIT]  = filt[IX_UV];
		set0[ST_TSD_BIT] = filt[IX_TSD];
		set0[ST_TW_BIT]  = filt[IX_TW];
		set1[ST_OC_LSB +: NUM_OUT] = filt[NUM_OUT-1:0];
	end

	// reset bit or a standby write wipes both reports; new events still land
	assign stat_clr = commit && (rx_word_reg[RESET_BIT] ||
		(!rx_word_reg[SEL_BIT] && !rx_word_reg[ENABLE_BIT]));

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stat0_reg <= STAT_RST;
			stat1_reg <= STAT_RST;
		end else begin
			stat0_reg <= (stat_clr ? STAT_RST : stat0_reg) | set0;
			stat1_reg <= (stat_clr ? STAT_RST : stat1_reg) | set1;
		end
	end

	assign nerr_next = !(|stat0_reg[ST_ERR_MSB:ST_ERR_LSB] ||
		|stat1_reg[ST_ERR_MSB:ST_ERR_LSB]);

	// snapshot frozen while a frame runs: the link needs a few core
	// cycles between select fall and the first clock rise
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nerr_reg  <= 1'b1;
			hold0_reg <= STAT_RST | REG_W'(1);
			hold1_reg <= STAT_RST | REG_W'(1);
		end else begin
			nerr_reg <= nerr_next;
			if (sync2_reg[IX_CSN]) begin
				hold0_reg <= {stat0_reg[REG_W-1:1], nerr_next};
				hold1_reg <= {stat1_reg[REG_W-1:1], nerr_next};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// over-current recovery modulator

	logic [REC_W-1:0]       rec_cnt_reg;
	logic [REC_W-1:0]       rec_per;
	logic [REC_W-1:0]       rec_on_cyc;
	logic                   rec_phase_on;

	always_comb begin
		if (ctl1_reg[FREQ_SEL_BIT]) begin
			rec_per    = REC_W'(REC_PER_HI);
			rec_on_cyc = ctl1_reg[DUTY_SEL_BIT] ? REC_W'(ON_HI_H) : REC_W'(ON_HI_L);
		end else begin
			rec_per    = REC_W'(REC_PER_LO);
			rec_on_cyc = ctl1_reg[DUTY_SEL_BIT] ? REC_W'(ON_LO_H) : REC_W'(ON_LO_L);
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			rec_cnt_reg <= '0;
		else if (rec_cnt_reg >= rec_per - 1'b1)
			rec_cnt_reg <= '0;
		else
			rec_cnt_reg <= rec_cnt_reg + 1'b1;
	end

	assign rec_phase_on = (rec_cnt_reg < rec_on_cyc);

	////////////////////////////////////////////////////////////////////////////////
	// driver enables

	logic                   sup_off;
	logic [NUM_OUT-1:0]     drv_next;
	logic [NUM_OUT-1:0]     drv_reg;
	logic [NUM_OUT-1:0]     pwm_vec;
	logic [NUM_OUT-1:0]     oc_flag;
	logic [NUM_OUT-1:0]     rec_en;
	logic [NUM_OUT-1:0]     pwm_en;
	logic [NUM_OUT-1:0]     out_ctl;

	// with recovery disabled the latched flag holds the outputs off
	assign sup_off = ctl0_reg[SUP_REC_DIS_BIT] ?
		(stat0_reg[ST_OV_BIT] || stat0_reg[ST_UV_BIT]) :
		(filt[IX_OV] || filt[IX_UV] || stat0_reg[ST_OV_BIT]);

	assign oc_flag = stat1_reg[ST_OC_LSB +: NUM_OUT];
	assign rec_en  = ctl1_reg[REC_EN_LSB +: NUM_OUT];
	assign pwm_en  = ctl1_reg[PWM_EN_LSB +: NUM_OUT];
	assign out_ctl = ctl0_reg[OUT_LSB +: NUM_OUT];

	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			pwm_vec[i]  = (i == PWM2_OUT) ? sync2_reg[IX_PWM2] : sync2_reg[IX_FIRST_MODULATION_INPUT];
			drv_next[i] = ctl0_reg[ENABLE_BIT] && !stat0_reg[ST_TSD_BIT] && !sup_off
				&& out_ctl[i] && (!pwm_en[i] || pwm_vec[i])
				&& (!oc_flag[i] || (rec_en[i] && rec_phase_on));
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			drv_reg <= '0;
		else
			drv_reg <= drv_next;
	end

	assign driver_on_o = drv_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_frame_commit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		commit && !rx_word_reg[SEL_BIT] |=> ctl0_reg == $past(rx_word_reg))
		else $error("accepted frame not written to control word zero");

	a_bad_frame: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_end && !commit |=> $stable(ctl0_reg) && $stable(ctl1_reg))
		else $error("wrong-length frame changed a control word");

	a_status_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		commit && rx_word_reg[RESET_BIT] |=>
		((stat0_reg & ~$past(set0)) == STAT_RST) && ((stat1_reg & ~$past(set1)) == STAT_RST))
		else $error("reset bit did not clear the fault reports");

	a_standby_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		commit && !rx_word_reg[SEL_BIT] && !rx_word_reg[ENABLE_BIT] |=> ##1 driver_on_o == '0)
		else $error("driver on after standby write");

	a_thermal_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		stat0_reg[ST_TSD_BIT] |=> driver_on_o == '0)
		else $error("driver on during thermal shutdown");

	a_oc_block: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		1'b1 |=> (driver_on_o & $past(oc_flag) & ~$past(rec_en)) == '0)
		else $error("tripped driver on without recovery");

	logic [FILT_W-1:0]      oc_run_reg;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			oc_run_reg <= '0;
		else
			oc_run_reg <= sync2_reg[0] ? oc_run_reg + (oc_run_reg < FILT_W'(FILT_CYC)) : '0;
	end
	a_oc_filter: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$rose(stat1_reg[ST_OC_LSB]) |-> $past(oc_run_reg) == FILT_W'(FILT_CYC))
		else $error("over-current flag set before filter expired");

	a_supply_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		stat0_reg[ST_OV_BIT] |=> driver_on_o == '0)
		else $error("driver on while supply fault flagged");

	a_noerr_poll: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		stat0_reg[ST_TW_BIT] |=> !nerr_reg)
		else $error("no-error bit high with a fault latched");

	a_out_hiz: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		select_low_input_n_i |-> !serial_out_oe_o)
		else $error("serial out driven while deselected");

	a_always_one: assert property (@(posedge sclk_i)
		disable iff (!resetn_i || select_low_input_n_i) !first_reg |-> tx_word_reg[ST_ONE_BIT])
		else $error("returned status bit 23 not one");

	a_rx_count: assert property (@(posedge sclk_i)
		disable iff (!resetn_i || select_low_input_n_i) first_reg |=> rx_cnt_reg == CNT_W'(1))
		else $error("bit count not restarted at frame start");

	c_write_zero: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		commit && !rx_word_reg[SEL_BIT]);
	c_write_one: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		commit && rx_word_reg[SEL_BIT]);
	c_discard: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_end && rx_cnt_reg != CNT_FULL);
	c_recovery: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		|(drv_reg & oc_flag));

endmodule

//--- tb/acsp_spi_master.sv
`timescale 1ns/1ps
// host-side serial master; one select line of its own, no chain
module acsp_spi_master (
	output logic      sclk_o,     // link clock, stops between frames
	output logic      csn_n_o,    // frame select
	output logic      mosi_o,     // data to device
	input  wire logic miso_i,     // device data out
	input  wire logic miso_oe_i   // device out enable
);
	wire miso_w = miso_oe_i ? miso_i : 1'bz;

	initial begin
		sclk_o  = 1'b0;
		csn_n_o = 1'b1;
		mosi_o  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one frame of nbits clocks; more or fewer than 24 is a deliberate fault
	task automatic xfer(input logic [23:0] w, input int nbits, output logic [23:0] rd);
		rd = '0;
		csn_n_o = 1'b0;
		#20;
		for (int i = 0; i < nbits; i++) begin
			mosi_o = (i < 24) ? w[i] : 1'b0;
			#3.75;
			if (i < 24) rd[i] = miso_w;
			sclk_o = 1'b1;
			#7.5;
			sclk_o = 1'b0;
			#3.75;
		end
		#10;
		csn_n_o = 1'b1;
		// released line must not keep showing the last bit
		mosi_o = ~mosi_o;
		#40;
	endtask

	task automatic poll(output logic fault_free, output logic oe);
		csn_n_o = 1'b0;
		#20;
		fault_free = miso_w;
		oe = miso_oe_i;
		csn_n_o = 1'b1;
		#40;
	endtask
endmodule

//--- tb/test_actuator_spi_control_port.sv
`timescale 1ns/1ps
module test_actuator_spi_control_port;
	import acsp_pkg::*;

	typedef struct packed {
		logic [23:0] w;
		logic        act;
		logic [1:0]  msel;
		logic [5:0]  drv;
	} acsp_row_t;

	logic        core_clk = 1'b0;
	logic        resetn   = 1'b0;
	logic        sclk;
	logic        csn_n;
	logic        mosi;
	logic        miso;
	logic        miso_oe;
	logic [5:0]  oc       = 6'h00;
	logic        ov       = 1'b0;
	logic        uv       = 1'b0;
	logic        thermal_shutdown_flag      = 1'b0;
	logic        tw       = 1'b0;
	logic        mod1     = 1'b0;
	logic        mod2     = 1'b0;
	logic [5:0]  drv;
	logic [1:0]  msel;
	logic        act;
	logic [23:0] rd;
	logic        ok;
	logic        oe;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          c;
	acsp_row_t   rows [6] = '{
		'{24'h80007e, 1'b1, 2'h0, 6'h3f},
		'{24'h840002, 1'b1, 2'h1, 6'h01},
		'{24'h880000, 1'b1, 2'h2, 6'h00},
		'{24'h8c0040, 1'b1, 2'h3, 6'h20},
		'{24'h0c007e, 1'b0, 2'h3, 6'h00},
		'{24'h840002, 1'b1, 2'h1, 6'h01}};

	always #2 core_clk = ~core_clk;

	acsp_top #(.FILT_CYC(8), .REC_PER_LO(200), .REC_PER_HI(100)) u_acsp_top (
		.core_clk_i(core_clk), .resetn_i(resetn), .sclk_i(sclk),
		.select_low_input_n_i(csn_n), .serial_in_pin_i(mosi), .serial_out_o(miso),
		.serial_out_oe_o(miso_oe), .overcurrent_i(oc), .overvoltage_i(ov),
		.undervoltage_i(uv), .thermal_shutdown_flag_i(thermal_shutdown_flag), .temp_warning_i(tw),
		.first_modulation_input_i(mod1), .monitor_or_second_modulation_pin_i(mod2),
		.driver_on_o(drv), .monitor_sel_o(msel), .active_o(act));

	acsp_spi_master u_acsp_spi_master (
		.sclk_o(sclk), .csn_n_o(csn_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// on-cycles of one driver over a window
	task automatic count_on(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (drv[0] === 1'b1) cnt++;
		end
	endtask

	task automatic wr(input logic [23:0] w);
		u_acsp_spi_master.xfer(w, 24, rd);
	endtask

	// ceiling well above the few thousand cycles the sequence needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		chk(24'(act), 24'h0);
		chk(24'(drv), 24'h0);
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk(24'(miso_oe), 24'h0);
		foreach (rows[i]) begin
			wr(rows[i].w);
			chk(24'(act), 24'(rows[i].act));
			chk(24'(msel), 24'(rows[i].msel));
			chk(24'(drv), 24'(rows[i].drv));
			chk(rd, 24'h800001);
		end
		// thermal shutdown: all off, wrong-length clear refused, then cleared
		@(posedge core_clk) thermal_shutdown_flag <= 1'b1;
		tw <= 1'b1;
		repeat (20) @(posedge core_clk);
		#1;
		chk(24'(drv), 24'h0);
		u_acsp_spi_master.poll(ok, oe);
		chk(24'(ok), 24'h0);
		chk(24'(oe), 24'h1);
		@(posedge core_clk) thermal_shutdown_flag <= 1'b0;
		tw <= 1'b0;
		u_acsp_spi_master.xfer(24'hc00002, 23, rd);
		chk(rd, 24'h180000);
		u_acsp_spi_master.xfer(24'hc00002, 25, rd);
		chk(rd, 24'h980000);
		chk(24'(drv), 24'h0);
		chk(24'(msel), 24'h1);
		wr(24'hc00002);
		chk(24'(drv), 24'h01);
		u_acsp_spi_master.poll(ok, oe);
		chk(24'(ok), 24'h1);
		// a glitch shorter than the filter must not trip
		@(posedge core_clk) oc[0] <= 1'b1;
		repeat (4) @(posedge core_clk);
		oc[0] <= 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
		chk(24'(drv), 24'h01);
		// recovery set only during start-up, as a lamp would need
		wr(24'h000081);
		@(posedge core_clk) oc[0] <= 1'b1;
		repeat (20) @(posedge core_clk);
		count_on(200, c);
		chk(24'(c), 24'd30);
		wr(24'h280081);
		chk(rd, 24'h800002);
		count_on(100, c);
		chk(24'(c), 24'd25);
		wr(24'h000001);
		count_on(300, c);
		chk(24'(c), 24'd0);
		@(posedge core_clk) oc[0] <= 1'b0;
		repeat (4) @(posedge core_clk);
		wr(24'hc00002);
		chk(24'(drv), 24'h01);
		// supply fault latched; a poll must not replay the last reset frame
		@(posedge core_clk) ov <= 1'b1;
		repeat (20) @(posedge core_clk);
		ov <= 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
		chk(24'(drv), 24'h0);
		u_acsp_spi_master.poll(ok, oe);
		chk(24'(ok), 24'h0);
		chk(24'(drv), 24'h0);
		wr(24'hc00022);
		chk(24'(drv), 24'h11);
		// modulation gating of drivers 0 and 4
		wr(24'h000023);
		chk(24'(drv), 24'h00);
		@(posedge core_clk) mod1 <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		chk(24'(drv), 24'h01);
		@(posedge core_clk) mod2 <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		chk(24'(drv), 24'h11);
		// reset in mid-run returns to standby
		@(posedge core_clk) resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		chk(24'(act), 24'h0);
		chk(24'(msel), 24'h0);
		chk(24'(drv), 24'h0);
		complete_run();
	end
endmodule
